// File: inc/load_move_pkg.sv
// Shared constants for the load and move datapath: register map, fields, opcodes and cycle counts.
package load_move_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned AMT_W         = 5;
   localparam int unsigned T_W           = 4;
   localparam int unsigned LOC_W         = 8;
   localparam int unsigned CNT_W         = 3;
   localparam int unsigned PAGE_IMM_W    = 10;
   localparam int unsigned T_LO          = 16;
   localparam int unsigned SHIFT_FIELD_LO       = 8;
   localparam int unsigned HALF_SEL      = 8;
   localparam int unsigned SUM_SIGN      = 31;
   localparam int unsigned INT_EN_CYCLES = 5;
   localparam logic [AMT_W-1:0] SHIFT_FULL = 5'h10;

   // ****************************************
   // Register byte offsets.
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EXT     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OPERAND = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_REPEAT  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_SUM     = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MULT    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PTR6    = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_PTR7    = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_PAGE    = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_INT_EN  = 8'h28;

   // Status register bit positions.
   localparam int unsigned ST_NEG   = 0;
   localparam int unsigned ST_ZERO  = 1;
   localparam int unsigned ST_SXM   = 2;
   localparam int unsigned ST_BUSY  = 3;
   localparam int unsigned ST_ARMED = 4;

   // ****************************************
   // Opcode masks and match values.
   // ****************************************
   localparam logic [WORD_W-1:0] OPM_FULL  = 16'hffff;
   localparam logic [WORD_W-1:0] OPM_BYTE  = 16'hff00;
   localparam logic [WORD_W-1:0] OPM_HALF  = 16'hfe00;
   localparam logic [WORD_W-1:0] OPM_PAGE  = 16'hfc00;
   localparam logic [WORD_W-1:0] OPM_K     = 16'hfff0;
   localparam logic [WORD_W-1:0] OPV_LD_T  = 16'h5606;
   localparam logic [WORD_W-1:0] OPV_LD_I  = 16'h5603;
   localparam logic [WORD_W-1:0] OPV_LD_0  = 16'h8500;
   localparam logic [WORD_W-1:0] OPV_LD_16 = 16'h2500;
   localparam logic [WORD_W-1:0] OPV_LD_K  = 16'hff20;
   localparam logic [WORD_W-1:0] OPV_PTR6  = 16'h5e00;
   localparam logic [WORD_W-1:0] OPV_PTR7  = 16'h5f00;
   localparam logic [WORD_W-1:0] OPV_HALF  = 16'h9200;
   localparam logic [WORD_W-1:0] OPV_PAGE  = 16'hf800;
   localparam logic [WORD_W-1:0] OPV_INTEN = 16'h2300;
   localparam logic [WORD_W-1:0] OPV_STC   = 16'h2800;
endpackage

// File: inc/shift_if.sv
// Carrier between the datapath and its operand shifter.
`timescale 1ns/1ps
`default_nettype none
interface shift_if;
   import load_move_pkg::*;
   logic [WORD_W-1:0] operand;
   logic [AMT_W-1:0]  amount;
   logic              sign_ext;
   logic [DATA_W-1:0] result;
   modport client  (output operand, output amount, output sign_ext, input result);
   modport shifter (input operand, input amount, input sign_ext, output result);
endinterface
`default_nettype wire

// File: verilog/operand_shifter.sv
// Extends a 16-bit operand and shifts it left into a 32-bit sum.
`timescale 1ns/1ps
`default_nettype none
module operand_shifter (
   shift_if.shifter port
);
   import load_move_pkg::*;

   logic [DATA_W-1:0] extended;

   always_comb begin
      extended    = {{(DATA_W-WORD_W){port.sign_ext & port.operand[WORD_W-1]}}, port.operand};
      // Bits pushed past the top are simply lost; no flag reports them.
      port.result = extended << port.amount;
   end
endmodule
`default_nettype wire

// File: verilog/accumulator_load_moves.sv
// Load and move instruction datapath with an APB register port.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Summary of operation
// - Variable-shift load takes its count from the multiplicand register upper half.
// - Only the four lowest count bits matter, shift 0 to 15.
// - Operand sign extends when sign mode is one, else zero extends; low bits zero.
// - Every sum load sets negative from sum bit 31.
// - Every sum load sets zero when the whole sum is zero.
// - A non-repeatable load after a repeat prefix clears the counter, runs once.
// - Immediate-shift load shifts left 0 to 16, zero when none given.
// - Pointer six or seven load writes low half only, keeps upper, no flags.
// - Half load writes the selected sum half, the other half is kept.
// - Half load flags: negative from bit 15, zero when the half is zero.
// - Page load writes bits 9..0 from the immediate, keeps bits 15..10, no flags.
// - Interrupt-enable load copies the whole word, no flags, five cycles.
// - Store-constant writes the second-word immediate; repeatable in N+1 cycles.
// ****************************************
module accumulator_load_moves #(
   parameter int unsigned REPEAT_W = 8
) (
   input  wire logic                               clk,
   input  wire logic                               srst,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [load_move_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [load_move_pkg::DATA_W-1:0]   pwdata,
   output logic      [load_move_pkg::DATA_W-1:0]   prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   output logic                                    store_valid,
   output logic      [load_move_pkg::WORD_W-1:0]   store_data,
   output logic      [load_move_pkg::LOC_W-1:0]    store_loc
);
   import load_move_pkg::*;

   typedef enum logic [1:0] {st_idle, st_wait, st_store} exec_state_t;

   if (REPEAT_W < 1 || REPEAT_W > WORD_W) begin : g_check
      $error("REPEAT_W must lie between 1 and 16.");
   end

   // ****************************************
   // State.
   // ****************************************
   exec_state_t         state_q, state_d;
   logic [CNT_W-1:0]    cnt_q, cnt_d;
   logic [DATA_W-1:0]   sum_q, sum_d;
   logic [DATA_W-1:0]   mult_q, mult_d;
   logic [DATA_W-1:0]   ptr6_q, ptr6_d;
   logic [DATA_W-1:0]   ptr7_q, ptr7_d;
   logic [WORD_W-1:0]   page_q, page_d;
   logic [WORD_W-1:0]   int_en_q, int_en_d;
   logic [WORD_W-1:0]   operand_q, operand_d;
   logic [WORD_W-1:0]   ext_q, ext_d;
   logic [WORD_W-1:0]   last_cmd_q, last_cmd_d;
   logic                sxm_q, sxm_d;
   logic                neg_q, neg_d;
   logic                zero_q, zero_d;
   logic [REPEAT_W-1:0] repeat_counter_q, repeat_counter_d;
   logic                armed_q, armed_d;
   logic [DATA_W-1:0]   prdata_q, prdata_d;
   logic                pready_q, pready_d;
   logic                pslverr_q, pslverr_d;
   logic                store_valid_q, store_valid_d;
   logic [WORD_W-1:0]   store_data_q, store_data_d;
   logic [LOC_W-1:0]    store_loc_q, store_loc_d;

   // ****************************************
   // Instruction decode.
   // ****************************************
   logic [WORD_W-1:0]   cmd;
   logic                op_ld_t, op_ld_i, op_ld_0, op_ld_16, op_ld_k, op_ld;
   logic                op_ptr6, op_ptr7, op_half, op_page, op_inten, op_stc;
   logic                op_valid, busy, hold, wr, take, repeating;
   logic [DATA_W-1:0]   status_w;

   assign cmd       = pwdata[WORD_W-1:0];
   assign op_ld_t   = (cmd & OPM_FULL) == OPV_LD_T;
   assign op_ld_i   = (cmd & OPM_FULL) == OPV_LD_I;
   assign op_ld_0   = (cmd & OPM_BYTE) == OPV_LD_0;
   assign op_ld_16  = (cmd & OPM_BYTE) == OPV_LD_16;
   assign op_ld_k   = (cmd & OPM_K) == OPV_LD_K;
   assign op_ptr6   = (cmd & OPM_BYTE) == OPV_PTR6;
   assign op_ptr7   = (cmd & OPM_BYTE) == OPV_PTR7;
   assign op_half   = (cmd & OPM_HALF) == OPV_HALF;
   assign op_page   = (cmd & OPM_PAGE) == OPV_PAGE;
   assign op_inten  = (cmd & OPM_BYTE) == OPV_INTEN;
   assign op_stc    = (cmd & OPM_BYTE) == OPV_STC;
   assign op_ld     = op_ld_t | op_ld_i | op_ld_0 | op_ld_16 | op_ld_k;
   assign op_valid  = op_ld | op_ptr6 | op_ptr7 | op_half | op_page | op_inten | op_stc;
   assign busy      = state_q != st_idle;
   assign repeating = armed_q && (repeat_counter_q != '0);
   // Issue and repeat-count writes wait in the access phase until execution is idle.
   assign hold      = pwrite && busy && (paddr == OFS_CMD || paddr == OFS_REPEAT);
   assign wr        = psel && penable && pready_q && pwrite;
   assign take      = wr && (paddr == OFS_CMD) && op_valid;

   // ****************************************
   // Operand shifter.
   // ****************************************
   shift_if sh ();

   assign sh.operand  = op_ld_k ? ext_q : operand_q;
   assign sh.sign_ext = sxm_q;
   assign sh.amount   = op_ld_t  ? {1'h0, mult_q[T_LO +: T_W]} :
                        op_ld_i  ? {1'h0, ext_q[SHIFT_FIELD_LO +: T_W]} :
                        op_ld_16 ? SHIFT_FULL :
                        op_ld_k  ? {1'h0, cmd[T_W-1:0]} :
                                   '0;

   operand_shifter u_shifter (
      .port (sh.shifter)
   );

   // ****************************************
   // Status word.
   // ****************************************
   always_comb begin
      status_w           = '0;
      status_w[ST_NEG]   = neg_q;
      status_w[ST_ZERO]  = zero_q;
      status_w[ST_SXM]   = sxm_q;
      status_w[ST_BUSY]  = busy;
      status_w[ST_ARMED] = armed_q;
   end

   // ****************************************
   // Next state.
   // ****************************************
   always_comb begin
      state_d       = state_q;
      cnt_d         = cnt_q;
      sum_d         = sum_q;
      mult_d        = mult_q;
      ptr6_d        = ptr6_q;
      ptr7_d        = ptr7_q;
      page_d        = page_q;
      int_en_d      = int_en_q;
      operand_d     = operand_q;
      ext_d         = ext_q;
      last_cmd_d    = last_cmd_q;
      sxm_d         = sxm_q;
      neg_d         = neg_q;
      zero_d        = zero_q;
      repeat_counter_d        = repeat_counter_q;
      armed_d       = armed_q;
      prdata_d      = '0;
      pready_d      = 1'h0;
      pslverr_d     = 1'h0;
      store_valid_d = 1'h0;
      store_data_d  = store_data_q;
      store_loc_d   = store_loc_q;

      // Register-bus answer is given in the second access cycle.
      if (psel && penable && !pready_q && !hold) begin
         pready_d = 1'h1;
         if (pwrite) begin
            unique case (paddr)
               OFS_CMD:     pslverr_d = !op_valid;
               OFS_EXT, OFS_OPERAND, OFS_STATUS, OFS_REPEAT, OFS_SUM,
               OFS_MULT, OFS_PTR6, OFS_PTR7, OFS_PAGE, OFS_INT_EN: pslverr_d = 1'h0;
               default:     pslverr_d = 1'h1;
            endcase
         end else begin
            unique case (paddr)
               OFS_CMD:     prdata_d = DATA_W'(last_cmd_q);
               OFS_EXT:     prdata_d = DATA_W'(ext_q);
               OFS_OPERAND: prdata_d = DATA_W'(operand_q);
               OFS_STATUS:  prdata_d = status_w;
               OFS_REPEAT:  prdata_d = DATA_W'(repeat_counter_q);
               OFS_SUM:     prdata_d = sum_q;
               OFS_MULT:    prdata_d = mult_q;
               OFS_PTR6:    prdata_d = ptr6_q;
               OFS_PTR7:    prdata_d = ptr7_q;
               OFS_PAGE:    prdata_d = DATA_W'(page_q);
               OFS_INT_EN:  prdata_d = DATA_W'(int_en_q);
               default:     pslverr_d = 1'h1;
            endcase
         end
      end

      // Plain register writes.
      if (wr) begin
         unique case (paddr)
            OFS_EXT:     ext_d     = pwdata[WORD_W-1:0];
            OFS_OPERAND: operand_d = pwdata[WORD_W-1:0];
            OFS_STATUS:  sxm_d     = pwdata[ST_SXM];
            OFS_REPEAT: begin
               repeat_counter_d  = pwdata[REPEAT_W-1:0];
               armed_d = 1'h1;
            end
            OFS_SUM:     sum_d     = pwdata;
            OFS_MULT:    mult_d    = pwdata;
            OFS_PTR6:    ptr6_d    = pwdata;
            OFS_PTR7:    ptr7_d    = pwdata;
            OFS_PAGE:    page_d    = pwdata[WORD_W-1:0];
            OFS_INT_EN:  int_en_d  = pwdata[WORD_W-1:0];
            default: begin
            end
         endcase
      end

      // Repeat and wait sequencing.
      unique case (state_q)
         st_idle: begin
         end
         st_wait: begin
            if (cnt_q == '0) begin
               state_d = st_idle;
            end else begin
               cnt_d = cnt_q - 1'h1;
            end
         end
         st_store: begin
            store_valid_d = 1'h1;
            repeat_counter_d        = repeat_counter_q - 1'h1;
            if (repeat_counter_q == REPEAT_W'(1)) begin
               state_d = st_idle;
               armed_d = 1'h0;
            end
         end
      endcase

      // Instruction execution.
      if (take) begin
         last_cmd_d = cmd;
         if (!op_stc) begin
            repeat_counter_d  = '0;
            armed_d = 1'h0;
         end
         if (op_ld) begin
            sum_d  = sh.result;
            neg_d  = sh.result[SUM_SIGN];
            zero_d = sh.result == '0;
         end
         if (op_ptr6) begin
            ptr6_d[WORD_W-1:0] = operand_q;
         end
         if (op_ptr7) begin
            ptr7_d[WORD_W-1:0] = operand_q;
         end
         if (op_half) begin
            if (cmd[HALF_SEL]) begin
               sum_d[DATA_W-1 -: WORD_W] = operand_q;
            end else begin
               sum_d[WORD_W-1:0] = operand_q;
            end
            neg_d  = operand_q[WORD_W-1];
            zero_d = operand_q == '0;
         end
         if (op_page) begin
            page_d[PAGE_IMM_W-1:0] = cmd[PAGE_IMM_W-1:0];
         end
         if (op_inten) begin
            int_en_d = operand_q;
            state_d  = st_wait;
            cnt_d    = CNT_W'(INT_EN_CYCLES - 2);
         end
         if (op_stc) begin
            store_valid_d = 1'h1;
            store_data_d  = ext_q;
            store_loc_d   = cmd[LOC_W-1:0];
            if (repeating) begin
               state_d = st_store;
            end else begin
               armed_d = 1'h0;
            end
         end
      end
   end

   // ****************************************
   // Registers.
   // ****************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q       <= st_idle;
         cnt_q         <= '0;
         sum_q         <= '0;
         mult_q        <= '0;
         ptr6_q        <= '0;
         ptr7_q        <= '0;
         page_q        <= '0;
         int_en_q      <= '0;
         operand_q     <= '0;
         ext_q         <= '0;
         last_cmd_q    <= '0;
         sxm_q         <= 1'h0;
         neg_q         <= 1'h0;
         zero_q        <= 1'h0;
         repeat_counter_q        <= '0;
         armed_q       <= 1'h0;
         prdata_q      <= '0;
         pready_q      <= 1'h0;
         pslverr_q     <= 1'h0;
         store_valid_q <= 1'h0;
         store_data_q  <= '0;
         store_loc_q   <= '0;
      end else begin
         state_q       <= state_d;
         cnt_q         <= cnt_d;
         sum_q         <= sum_d;
         mult_q        <= mult_d;
         ptr6_q        <= ptr6_d;
         ptr7_q        <= ptr7_d;
         page_q        <= page_d;
         int_en_q      <= int_en_d;
         operand_q     <= operand_d;
         ext_q         <= ext_d;
         last_cmd_q    <= last_cmd_d;
         sxm_q         <= sxm_d;
         neg_q         <= neg_d;
         zero_q        <= zero_d;
         repeat_counter_q        <= repeat_counter_d;
         armed_q       <= armed_d;
         prdata_q      <= prdata_d;
         pready_q      <= pready_d;
         pslverr_q     <= pslverr_d;
         store_valid_q <= store_valid_d;
         store_data_q  <= store_data_d;
         store_loc_q   <= store_loc_d;
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign store_valid = store_valid_q;
   assign store_data  = store_data_q;
   assign store_loc   = store_loc_q;

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   logic [DATA_W-1:0] op_ext;
   assign op_ext = {{(DATA_W-WORD_W){sxm_q & operand_q[WORD_W-1]}}, operand_q};

   chk_var_shift_src: assert property (take && op_ld_t |=>
      sum_q == ($past(op_ext) << $past(mult_q[T_LO +: T_W])))
      else $error("Variable-shift load used the wrong count.");
   chk_ext_fill: assert property (take && op_ld_0 |=>
      sum_q[DATA_W-1:WORD_W] == {WORD_W{$past(sxm_q && operand_q[WORD_W-1])}})
      else $error("Operand extension does not follow sign mode.");
   chk_neg_flag: assert property (take && op_ld |=> neg_q == sum_q[SUM_SIGN])
      else $error("Negative flag does not match sum bit 31.");
   chk_zero_flag: assert property (take && op_ld |=> zero_q == (sum_q == '0))
      else $error("Zero flag does not match the sum.");
   chk_repeat_clear: assert property (take && !op_stc |=>
      repeat_counter_q == '0 && !armed_q && !store_valid_q ##1 !store_valid_q)
      else $error("Non-repeatable load left the repeat counter set.");
   chk_shift_sixteen: assert property (take && op_ld_16 |=>
      sum_q == {$past(operand_q), {WORD_W{1'h0}}})
      else $error("Shift by sixteen gave a wrong sum.");
   chk_ptr_upper: assert property (take && op_ptr6 |=>
      ptr6_q == {$past(ptr6_q[DATA_W-1:WORD_W]), $past(operand_q)} && $stable(neg_q) && $stable(zero_q))
      else $error("Pointer load disturbed the upper half or the flags.");
   chk_half_other: assert property (take && op_half && cmd[HALF_SEL] |=>
      sum_q[WORD_W-1:0] == $past(sum_q[WORD_W-1:0]))
      else $error("High-half load changed the low half.");
   chk_half_flags: assert property (take && op_half |=>
      neg_q == $past(operand_q[WORD_W-1]) && zero_q == ($past(operand_q) == '0))
      else $error("Half load flags are wrong.");
   chk_page_upper: assert property (take && op_page |=>
      page_q[WORD_W-1:PAGE_IMM_W] == $past(page_q[WORD_W-1:PAGE_IMM_W]))
      else $error("Page load changed the upper page bits.");
   chk_inten_cycles: assert property (take && op_inten |=> busy [*4] ##1 !busy)
      else $error("Interrupt-enable load did not take five cycles.");
   chk_store_once: assert property (take && op_stc && !repeating |=> store_valid_q ##1 !store_valid_q)
      else $error("Single store-constant did not write once.");
   chk_store_twice: assert property (take && op_stc && armed_q && repeat_counter_q == REPEAT_W'(1) |=>
      store_valid_q [*2] ##1 !store_valid_q)
      else $error("Repeated store-constant did not write N+1 times.");

   cov_inten: cover property (take && op_inten);
   cov_store_rep: cover property (state_q == st_store && repeat_counter_q > REPEAT_W'(1));
   cov_const_load: cover property (take && op_ld_k);
   cov_half_low: cover property (take && op_half && !cmd[HALF_SEL]);
endmodule
`default_nettype wire

// File: testbench/accumulator_load_moves_test.sv
// Self-checking testbench for the load and move datapath, driven over APB.
`timescale 1ns/1ps
`default_nettype none
module accumulator_load_moves_test;
   import load_move_pkg::*;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              store_valid;
   logic [WORD_W-1:0] store_data;
   logic [LOC_W-1:0]  store_loc;
   int                n_errors = 0;
   int                n_tests = 0;
   int                n_pulse = 0;
   logic [31:0]       v;
   logic              e;
   // Table of sum loads: opcode, second word, operand, sign mode, sum, status {sxm, zero, neg}.
   logic [15:0]       t_op[6] = '{16'h8511, 16'h5603, 16'h2522, 16'hff24, 16'hff20, 16'h2500};
   logic [15:0]       t_ext[6] = '{16'h0000, 16'h0f00, 16'h0000, 16'hfff0, 16'h0000, 16'h0000};
   logic [15:0]       t_mem[6] = '{16'h8000, 16'h0003, 16'h8001, 16'h0000, 16'h0000, 16'h0000};
   logic              t_sxm[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [31:0]       t_sum[6] = '{32'hffff8000, 32'h00018000, 32'h80010000, 32'hffffff00, 32'h0, 32'h0};
   logic [2:0]        t_st[6] = '{3'b101, 3'b000, 3'b101, 3'b101, 3'b010, 3'b110};

   accumulator_load_moves DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .store_valid(store_valid), .store_data(store_data), .store_loc(store_loc));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      if (store_valid === 1'b1) begin
         n_pulse++;
      end
   end

   // ****************************************
   // Bus access and comparison tasks.
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic er);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 200);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 200) begin
         n_errors++;
         $display("mismatch pready expected 1 seen %b", pready);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, d, r, er);
      chk("write error", 32'h0, {31'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic er;
      apb(1'b0, a, 32'h0, r, er);
   endtask

   task automatic ld(input logic [15:0] op, input logic [15:0] mem);
      wr(OFS_OPERAND, {16'h0, mem});
      wr(OFS_CMD, {16'h0, op});
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Test sequence.
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(OFS_SUM, v);
      chk("sum reset", 32'h0, v);
      rd(OFS_STATUS, v);
      chk("status reset", 32'h0, v);
      wr(OFS_STATUS, 32'h4);
      wr(OFS_MULT, 32'hfff3_1234);
      wr(OFS_REPEAT, 32'h3);
      ld(OPV_LD_T, 16'h8001);
      rd(OFS_SUM, v);
      chk("sum var shift signed", 32'hfffc0008, v);
      rd(OFS_STATUS, v);
      chk("status var shift", 32'h5, {27'h0, v[4:0]});
      rd(OFS_REPEAT, v);
      chk("repeat counter", 32'h0, v);
      wr(OFS_STATUS, 32'h0);
      ld(OPV_LD_T, 16'h8001);
      rd(OFS_SUM, v);
      chk("sum var shift unsigned", 32'h00040008, v);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_STATUS, {29'h0, t_sxm[i], 2'b00});
         wr(OFS_EXT, {16'h0, t_ext[i]});
         wr(OFS_REPEAT, 32'h2);
         ld(t_op[i], t_mem[i]);
         rd(OFS_SUM, v);
         chk("sum imm shift", t_sum[i], v);
         rd(OFS_STATUS, v);
         chk("status imm shift", {29'h0, t_st[i]}, {27'h0, v[4:0]});
         rd(OFS_REPEAT, v);
         chk("repeat after load", 32'h0, v);
      end
      wr(OFS_PTR6, 32'habcd0000);
      ld(OPV_PTR6, 16'h5555);
      rd(OFS_PTR6, v);
      chk("pointer six", 32'habcd5555, v);
      wr(OFS_PTR7, 32'h0000ffff);
      ld(OPV_PTR7, 16'h1234);
      rd(OFS_PTR7, v);
      chk("pointer seven", 32'h00001234, v);
      rd(OFS_STATUS, v);
      chk("status after pointers", 32'h6, {29'h0, v[2:0]});
      wr(OFS_SUM, 32'h12345678);
      ld(OPV_HALF | 16'h0100, 16'h8000);
      rd(OFS_SUM, v);
      chk("high half load", 32'h80005678, v);
      rd(OFS_STATUS, v);
      chk("high half flags", 32'h1, {30'h0, v[1:0]});
      ld(OPV_HALF, 16'h0000);
      rd(OFS_SUM, v);
      chk("low half load", 32'h80000000, v);
      rd(OFS_STATUS, v);
      chk("low half flags", 32'h2, {30'h0, v[1:0]});
      wr(OFS_PAGE, 32'hffff);
      wr(OFS_CMD, {16'h0, OPV_PAGE | 16'h0155});
      rd(OFS_PAGE, v);
      chk("page pointer", 32'hfd55, v);
      ld(OPV_INTEN, 16'hbeef);
      rd(OFS_STATUS, v);
      chk("busy and flags after int enable", 32'he, {28'h0, v[3:0]});
      rd(OFS_INT_EN, v);
      chk("interrupt enable", 32'hbeef, v);
      n_pulse = 0;
      wr(OFS_EXT, 32'h7777);
      wr(OFS_REPEAT, 32'h2);
      wr(OFS_CMD, {16'h0, OPV_STC | 16'h0042});
      wr(OFS_REPEAT, 32'h0);
      chk("repeated store count", 32'h3, n_pulse);
      chk("store data", 32'h7777, {16'h0, store_data});
      chk("store location", 32'h42, {24'h0, store_loc});
      n_pulse = 0;
      wr(OFS_CMD, {16'h0, OPV_STC | 16'h0011});
      rd(OFS_REPEAT, v);
      chk("single store count", 32'h1, n_pulse);
      chk("single store location", 32'h11, {24'h0, store_loc});
      wr(OFS_REPEAT, 32'h1);
      n_pulse = 0;
      wr(OFS_CMD, {16'h0, OPV_STC | 16'h0033});
      rd(OFS_REPEAT, v);
      chk("store count one repeat", 32'h2, n_pulse);
      chk("repeat after store", 32'h0, v);
      chk("store location one repeat", 32'h33, {24'h0, store_loc});
      apb(1'b0, 8'h3c, 32'h0, v, e);
      chk("unmapped read error", 32'h1, {31'h0, e});
      chk("unmapped read data", 32'h0, v);
      apb(1'b1, OFS_CMD, 32'h0, v, e);
      chk("unknown opcode error", 32'h1, {31'h0, e});
      rd(OFS_SUM, v);
      chk("sum after unknown opcode", 32'h80000000, v);
      rd(OFS_CMD, v);
      chk("last command", {16'h0, OPV_STC | 16'h0033}, v);
      end_sim;
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      $display("mismatch watchdog expected done seen running");
      end_sim;
   end
endmodule
`default_nettype wire
